/* core/tcc_capture_compare.sv */
// Input capture and output compare units of a 16-bit timer
`timescale 1ns/1ps

// Overview of operation
// - Selected edge copies counter into capture register
// - Capture flag set in the copy cycle
// - Capture request when enabled; service clears flag
// - Writing one clears the capture flag
// - Low capture read loads shared high latch
// - Capture writable only in capture-top modes
// - Select bit routes comparator as capture trigger
// - Both triggers synchronised; filter adds four cycles
// - Capture triggering off in capture-top modes
// - Driving the pin itself can trigger capture
// - Filter output moves after four agreeing samples
// - Filter enabled in control B, system clock
// - Every capture overwrites the previous value
// - Equality match sets compare flag on tick
// - Compare request when enabled; service or one clears
// - PWM modes double buffer; others bypass buffer
// - CPU reaches buffer or active register accordingly
// - High write to latch; low write moves both
// - Compare reads bypass the shared high latch
// - Force strobe acts as match in non-PWM modes only, no flag
// - Counter write blocks matches at next tick
// - Output mode field is never buffered
module tcc_capture_compare
  import tcc_pkg::*;
#(
  parameter int unsigned ADDR_W = 4
)
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic capture_input_pin_in,
  input wire logic comparator_output_in,
  input wire logic [CNT_W-1:0] counter_value_in,
  input wire logic timer_tick_in,
  input wire logic top_in,
  input wire logic bottom_in,
  input wire logic counter_write_in,
  input wire logic capture_ack_in,
  input wire logic [CHANNELS-1:0] compare_ack_in,
  output logic capture_irq_out,
  output logic [CHANNELS-1:0] compare_irq_out,
  output logic [CHANNELS-1:0] match_out,
  output logic [CHANNELS-1:0] force_out,
  output logic [3:0] waveform_mode_out,
  output logic [CHANNELS-1:0][1:0] compare_output_mode_out,
  output logic [CHANNELS-1:0][CNT_W-1:0] compare_value_out,
  output logic [CNT_W-1:0] capture_value_out
);

  if (ADDR_W < 4)
  begin : g_addr_check
    $error("ADDR_W must be at least 4");
  end

  // The byte map holds two channels of 16-bit values, two bytes each
  if (CNT_W != 16)
  begin : g_width_check
    $error("CNT_W must be 16");
  end

  if (CHANNELS != 2)
  begin : g_channel_check
    $error("CHANNELS must be 2");
  end

  // The agreement vote needs a history of at least two samples
  if (FILTER_SAMPLES < 2)
  begin : g_filter_check
    $error("FILTER_SAMPLES must be at least 2");
  end

  tcc_state_s state_reg;
  tcc_state_s state_next;
  logic [3:0] addr;
  logic src;
  logic det;
  logic cap_evt;
  logic pwm;
  logic cap_top;
  logic suppress;
  logic cap_clr;
  logic [CHANNELS-1:0] cmp_clr;
  logic [CHANNELS-1:0] hit;

  // Twelve of the sixteen modes are PWM; 0, 4, 12 and 13 are not
  function automatic logic is_pwm(input logic [3:0] wgm);
    is_pwm = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC || wgm == 4'hD);
  endfunction

  function automatic logic uses_capture_top(input logic [3:0] wgm);
    uses_capture_top = (wgm == 4'h8 || wgm == 4'hA || wgm == 4'hC || wgm == 4'hE);
  endfunction

  // Phase correct modes reload at TOP, the other PWM modes at BOTTOM
  function automatic logic reload_at_top(input logic [3:0] wgm);
    reload_at_top = (wgm == 4'h1 || wgm == 4'h2 || wgm == 4'h3 || wgm == 4'hA ||
                     wgm == 4'hB);
  endfunction

  function automatic logic [3:0] cmp_addr(input int unsigned ch, input logic hi);
    cmp_addr = 4'(ADDR_CMP_L_BASE + 2 * ch + int'(hi));
  endfunction

  assign addr = addr_in[3:0];

  always_comb
  begin
    state_next = state_reg;
    src = 1'b0;
    det = 1'b0;
    cap_evt = 1'b0;
    cap_clr = capture_ack_in;
    cmp_clr = compare_ack_in;
    hit = '0;
    pwm = is_pwm(state_reg.wgm);
    cap_top = uses_capture_top(state_reg.wgm);
    state_next.rdata = 8'h00;
    state_next.match = '0;
    state_next.force_cmp = '0;

    // pin level sampled regardless of direction
    state_next.sync_pin = {state_reg.sync_pin[0], capture_input_pin_in};
    state_next.sync_cmp = {state_reg.sync_cmp[0], comparator_output_in};
    src = state_reg.cmp_sel ? state_reg.sync_cmp[1] : state_reg.sync_pin[1];

    // four agreeing samples
    // Newest sample takes part in the vote, so the filter adds exactly four cycles
    state_next.filt_hist = {state_reg.filt_hist[FILTER_SAMPLES-2:0], src};
    if (&state_next.filt_hist)
    begin
      state_next.filt_level = 1'b1;
    end
    else if (~|state_next.filt_hist)
    begin
      state_next.filt_level = 1'b0;
    end
    det = state_reg.filter_en ? state_reg.filt_level : src;
    state_next.edge_prev = det;

    cap_evt = !cap_top && (state_reg.edge_rise ? (det && !state_reg.edge_prev) :
                                                 (!det && state_reg.edge_prev));
    if (cap_evt)
    begin
      state_next.capture = counter_value_in;
    end

    // reload active value at TOP or BOTTOM
    if (pwm && timer_tick_in && (reload_at_top(state_reg.wgm) ? top_in : bottom_in))
    begin
      state_next.cmp_act = state_reg.cmp_buf;
    end

    // block matches until the next tick
    suppress = state_reg.block_pending || counter_write_in;
    state_next.block_pending = counter_write_in || (state_reg.block_pending && !timer_tick_in);

    if (wr_in)
    begin
      if (addr == ADDR_CTRL_A)
      begin
        for (int c = 0; c < CHANNELS; c++)
        begin
          state_next.com[c] = wdata_in[CTRLA_COM_A_LSB - 2 * c +: 2];
        end
        state_next.wgm[1:0] = wdata_in[CTRLA_WGM_LO_LSB +: 2];
      end
      else if (addr == ADDR_CTRL_B)
      begin
        state_next.filter_en = wdata_in[CTRLB_FILTER_BIT];
        state_next.edge_rise = wdata_in[CTRLB_EDGE_BIT];
        state_next.wgm[3:2] = wdata_in[CTRLB_WGM_HI_LSB +: 2];
      end
      else if (addr == ADDR_CTRL_C)
      begin
        for (int c = 0; c < CHANNELS; c++)
        begin
          state_next.force_cmp[c] = !pwm && wdata_in[CTRLC_FORCE_A_BIT - c];
        end
      end
      else if (addr == ADDR_CAP_L)
      begin
        // write only when capture defines TOP
        if (cap_top)
        begin
          state_next.capture = {state_reg.temp, wdata_in};
        end
      end
      else if (addr == ADDR_CAP_H)
      begin
        state_next.temp = wdata_in;
      end
      else if (addr == ADDR_IRQ_MASK)
      begin
        state_next.cap_ie = wdata_in[CAP_BIT];
        for (int c = 0; c < CHANNELS; c++)
        begin
          state_next.cmp_ie[c] = wdata_in[CMP_A_BIT + c];
        end
      end
      else if (addr == ADDR_FLAGS)
      begin
        cap_clr = cap_clr || wdata_in[CAP_BIT];
        for (int c = 0; c < CHANNELS; c++)
        begin
          cmp_clr[c] = cmp_clr[c] || wdata_in[CMP_A_BIT + c];
        end
      end
      else if (addr == ADDR_CMP_CTRL)
      begin
        state_next.cmp_sel = wdata_in[CMP_SEL_BIT];
      end
      else
      begin
        for (int c = 0; c < CHANNELS; c++)
        begin
          if (addr == cmp_addr(c, 1'b1))
          begin
            state_next.temp = wdata_in;
          end
          else if (addr == cmp_addr(c, 1'b0))
          begin
            // both bytes move together
            // Buffer follows in bypass too, so entering PWM keeps the last value
            state_next.cmp_buf[c] = {state_reg.temp, wdata_in};
            if (!pwm)
            begin
              state_next.cmp_act[c] = {state_reg.temp, wdata_in};
            end
          end
        end
      end
    end

    if (rd_in)
    begin
      if (addr == ADDR_CTRL_A)
      begin
        state_next.rdata = {state_reg.com[0], state_reg.com[1], 2'b00, state_reg.wgm[1:0]};
      end
      else if (addr == ADDR_CTRL_B)
      begin
        state_next.rdata = {state_reg.filter_en, state_reg.edge_rise, 1'b0,
                            state_reg.wgm[3:2], 3'b000};
      end
      else if (addr == ADDR_CAP_L)
      begin
        // low read snapshots the high byte
        state_next.rdata = state_reg.capture[7:0];
        state_next.temp = state_reg.capture[15:8];
      end
      else if (addr == ADDR_CAP_H)
      begin
        state_next.rdata = state_reg.temp;
      end
      else if (addr == ADDR_IRQ_MASK)
      begin
        state_next.rdata = {2'b00, state_reg.cap_ie, 2'b00, state_reg.cmp_ie, 1'b0};
      end
      else if (addr == ADDR_FLAGS)
      begin
        state_next.rdata = {2'b00, state_reg.cap_flag, 2'b00, state_reg.cmp_flag, 1'b0};
      end
      else if (addr == ADDR_CMP_CTRL)
      begin
        state_next.rdata = {5'b00000, state_reg.cmp_sel, 2'b00};
      end
      else
      begin
        for (int c = 0; c < CHANNELS; c++)
        begin
          // compare reads are direct, no latch
          if (addr == cmp_addr(c, 1'b0))
          begin
            state_next.rdata = pwm ? state_reg.cmp_buf[c][7:0] : state_reg.cmp_act[c][7:0];
          end
          else if (addr == cmp_addr(c, 1'b1))
          begin
            state_next.rdata = pwm ? state_reg.cmp_buf[c][15:8] : state_reg.cmp_act[c][15:8];
          end
        end
      end
    end

    // flag set with the copy; a new event beats a clear
    state_next.cap_flag = (state_reg.cap_flag && !cap_clr) || cap_evt;
    state_next.cap_irq = state_next.cap_flag && state_next.cap_ie;

    for (int c = 0; c < CHANNELS; c++)
    begin
      // equality sampled at the timer tick
      hit[c] = timer_tick_in && !suppress && (counter_value_in == state_reg.cmp_act[c]);
      state_next.match[c] = hit[c];
      // set wins over acknowledge or write-one clear
      state_next.cmp_flag[c] = (state_reg.cmp_flag[c] && !cmp_clr[c]) || hit[c];
      state_next.cmp_irq[c] = state_next.cmp_flag[c] && state_next.cmp_ie[c];
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      state_reg <= STATE_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata_out = state_reg.rdata;
  assign capture_irq_out = state_reg.cap_irq;
  assign compare_irq_out = state_reg.cmp_irq;
  assign match_out = state_reg.match;
  assign force_out = state_reg.force_cmp;
  assign waveform_mode_out = state_reg.wgm;
  assign compare_output_mode_out = state_reg.com;
  assign compare_value_out = state_reg.cmp_act;
  assign capture_value_out = state_reg.capture;

endmodule

/* core/tcc_pkg.sv */
// Constants and state carrier for the timer capture and compare units
package tcc_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned CHANNELS = 2;
  localparam int unsigned FILTER_SAMPLES = 4;

  // Register byte addresses on the 8-bit register port
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_CTRL_C = 4'h2;
  localparam logic [3:0] ADDR_CAP_L = 4'h4;
  localparam logic [3:0] ADDR_CAP_H = 4'h5;
  localparam logic [3:0] ADDR_CMP_L_BASE = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hA;
  localparam logic [3:0] ADDR_FLAGS = 4'hB;
  localparam logic [3:0] ADDR_CMP_CTRL = 4'hC;

  // Field positions
  localparam int unsigned CTRLA_COM_A_LSB = 6;
  localparam int unsigned CTRLA_WGM_LO_LSB = 0;
  localparam int unsigned CTRLB_FILTER_BIT = 7;
  localparam int unsigned CTRLB_EDGE_BIT = 6;
  localparam int unsigned CTRLB_WGM_HI_LSB = 3;
  localparam int unsigned CTRLC_FORCE_A_BIT = 7;
  localparam int unsigned CAP_BIT = 5;
  localparam int unsigned CMP_A_BIT = 1;
  localparam int unsigned CMP_SEL_BIT = 2;

  typedef struct packed {
    logic [1:0] sync_pin;
    logic [1:0] sync_cmp;
    logic [FILTER_SAMPLES-1:0] filt_hist;
    logic filt_level;
    logic edge_prev;
    logic [CNT_W-1:0] capture;
    logic [7:0] temp;
    logic [CHANNELS-1:0][CNT_W-1:0] cmp_buf;
    logic [CHANNELS-1:0][CNT_W-1:0] cmp_act;
    logic [3:0] wgm;
    logic [CHANNELS-1:0][1:0] com;
    logic filter_en;
    logic edge_rise;
    logic cmp_sel;
    logic cap_flag;
    logic cap_ie;
    logic cap_irq;
    logic [CHANNELS-1:0] cmp_flag;
    logic [CHANNELS-1:0] cmp_ie;
    logic [CHANNELS-1:0] cmp_irq;
    logic [CHANNELS-1:0] match;
    logic [CHANNELS-1:0] force_cmp;
    logic block_pending;
    logic [7:0] rdata;
  } tcc_state_s;

  localparam tcc_state_s STATE_RST = '0;

endpackage

/* dv/tcc_monitor.sv */
// Port-level assertions for the capture and compare block
`timescale 1ns/1ps
module tcc_monitor
  import tcc_pkg::*;
#(
  parameter int unsigned ADDR_W = 4
)
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic [CNT_W-1:0] counter_value_in,
  input wire logic timer_tick_in,
  input wire logic top_in,
  input wire logic bottom_in,
  input wire logic counter_write_in,
  input wire logic [CHANNELS-1:0] compare_ack_in,
  input wire logic [CHANNELS-1:0] compare_irq_out,
  input wire logic [CHANNELS-1:0] match_out,
  input wire logic [CHANNELS-1:0] force_out,
  input wire logic [3:0] waveform_mode_out,
  input wire logic [CHANNELS-1:0][1:0] compare_output_mode_out,
  input wire logic [CHANNELS-1:0][CNT_W-1:0] compare_value_out,
  input wire logic [CNT_W-1:0] capture_value_out
);
  logic cap_top;
  logic pwm;
  assign cap_top = waveform_mode_out inside {4'h8, 4'hA, 4'hC, 4'hE};
  assign pwm = !(waveform_mode_out inside {4'h0, 4'h4, 4'hC, 4'hD});
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  sequence wr_then_tick;
    counter_write_in ##1 (timer_tick_in && !counter_write_in);
  endsequence
  sequence ack_quiet;
    (compare_ack_in[0] && !timer_tick_in) ##1 !timer_tick_in;
  endsequence
  // Output may lag the copy by one register stage
  cap_copy_a: assert property (
    $changed(capture_value_out) && !cap_top |-> capture_value_out == $past(counter_value_in)
      || capture_value_out == $past(counter_value_in, 2))
    else $error("capture value is not a counter sample");
  cap_topmode_a: assert property (
    cap_top && $past(cap_top) && $past(cap_top, 2) && $changed(capture_value_out)
      |-> $past(wr_in) || $past(wr_in, 2))
    else $error("capture changed in a capture-top mode");
  match_cause_a: assert property (
    match_out[0] |-> $past(timer_tick_in)
      && $past(counter_value_in) == $past(compare_value_out[0]))
    else $error("match without tick and equality");
  match_block_a: assert property (
    wr_then_tick |=> match_out == 2'b00)
    else $error("match after counter write");
  cmp_ack_a: assert property (
    ack_quiet |=> !compare_irq_out[0])
    else $error("compare request survives service");
  force_cause_a: assert property (
    force_out[0] |-> $past(wr_in) && $past(addr_in) == ADDR_CTRL_C && $past(wdata_in[7]) && !pwm)
    else $error("force pulse without strobe");
  com_direct_a: assert property (
    wr_in && addr_in == ADDR_CTRL_A |=> compare_output_mode_out[0] == $past(wdata_in[7:6])
      && compare_output_mode_out[1] == $past(wdata_in[5:4]))
    else $error("output mode not taken at once");
  pwm_reload_a: assert property (
    pwm && $past(pwm) && $past(pwm, 2) && $changed(compare_value_out[1])
      |-> $past(timer_tick_in) && ($past(top_in) || $past(bottom_in)))
    else $error("active compare moved outside reload");
endmodule

bind tcc_capture_compare tcc_monitor #(.ADDR_W(ADDR_W)) u_mon (.clock_in(clock_in),
  .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .counter_value_in(counter_value_in), .timer_tick_in(timer_tick_in), .top_in(top_in),
  .bottom_in(bottom_in), .counter_write_in(counter_write_in),
  .compare_ack_in(compare_ack_in), .compare_irq_out(compare_irq_out),
  .match_out(match_out), .force_out(force_out), .waveform_mode_out(waveform_mode_out),
  .compare_output_mode_out(compare_output_mode_out),
  .compare_value_out(compare_value_out), .capture_value_out(capture_value_out));

/* dv/tcc_counter_model.sv */
// Behavioural counter unit driving the block's counter inputs
`timescale 1ns/1ps
module tcc_counter_model
  import tcc_pkg::*;
(
  input wire logic clock_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [CNT_W-1:0] load_val_in,
  output logic [CNT_W-1:0] count_out,
  output logic tick_out,
  output logic top_out,
  output logic bottom_out
);
  // Bench gates run_in; tick_out fires on every clock while it is high
  assign tick_out = run_in;
  assign top_out = count_out == 16'hFFFF;
  assign bottom_out = count_out == 16'h0000;
  always_ff @(posedge clock_in)
  begin
    if (load_in)
      count_out <= load_val_in;
    else if (run_in)
      count_out <= count_out + 16'h0001;
  end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the capture and compare block
`timescale 1ns/1ps
module testbench import tcc_pkg::*;;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic wr = 1'b0, rd = 1'b0, pin = 1'b0, cmpo = 1'b0, run = 1'b0, load = 1'b0, cap_ack = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, lo, hi;
  logic [1:0] cmp_ack = 2'h0, cmp_irq, match, frc;
  logic [15:0] ld_val = 16'h0000, cnt, v, w, capx, capv;
  logic tick, top, bot, cap_irq;
  logic [3:0] wgm;
  logic [1:0][1:0] com;
  logic [1:0][15:0] cval;
  int seed = 32, error_cnt = 0, n_compared = 0, cyc = 0, k;
  always #5 clock_in = ~clock_in;
  tcc_counter_model u_tcc_counter_model (.clock_in(clock_in), .run_in(run), .load_in(load),
    .load_val_in(ld_val), .count_out(cnt), .tick_out(tick), .top_out(top), .bottom_out(bot));
  tcc_capture_compare u_tcc_capture_compare (.clock_in(clock_in), .srst_in(srst_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .capture_input_pin_in(pin), .comparator_output_in(cmpo), .counter_value_in(cnt),
    .timer_tick_in(tick), .top_in(top), .bottom_in(bot), .counter_write_in(load),
    .capture_ack_in(cap_ack), .compare_ack_in(cmp_ack), .capture_irq_out(cap_irq),
    .compare_irq_out(cmp_irq), .match_out(match), .force_out(frc), .waveform_mode_out(wgm),
    .compare_output_mode_out(com), .compare_value_out(cval), .capture_value_out(capv));
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    @(negedge clock_in);
    d = rdata;
  endtask
  task automatic rdcap(output logic [15:0] d);
    rd8(ADDR_CAP_L, d[7:0]);
    rd8(ADDR_CAP_H, d[15:8]);
  endtask
  task automatic ld(input logic [15:0] d);
    @(posedge clock_in);
    ld_val <= d;
    load <= 1'b1;
    @(posedge clock_in);
    load <= 1'b0;
  endtask
  task automatic ack(input logic c, input logic [1:0] m);
    @(posedge clock_in);
    cap_ack <= c;
    cmp_ack <= m;
    @(posedge clock_in);
    cap_ack <= 1'b0;
    cmp_ack <= 2'b00;
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic pin_to(input logic l, output int n);
    @(posedge clock_in);
    pin <= l;
    #1;
    n = 0;
    while (cap_irq !== 1'b1 && n < 20)
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
  endtask
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      conclude();
    end
  end
  initial
  begin
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    wr8(ADDR_IRQ_MASK, 8'h26);
    for (int f = 0; f < 2; f++)
    begin
      v = 16'($random(seed));
      ld(v);
      wr8(ADDR_CTRL_B, f ? 8'hC0 : 8'h40);
      pin_to(1'b1, k);
      chk(16'(k), 16'(3 + f * FILTER_SAMPLES));
      chk(capv, v);
      rdcap(capx);
      chk(capx, v);
      if (f == 0)
        wr8(ADDR_FLAGS, 8'h20);
      else
        ack(1'b1, 2'b00);
      chk(cap_irq, 1'b0);
      pin_to(1'b0, k);
      chk(cap_irq, 1'b0);
    end
    wr8(ADDR_CAP_H, 8'h5A);
    wr8(ADDR_CAP_L, 8'hA5);
    rdcap(w);
    chk(w, capx);
    wr8(ADDR_CTRL_B, 8'h80);
    pin_to(1'b1, k);
    @(posedge clock_in);
    pin <= 1'b0;
    idle(2);
    pin_to(1'b1, k);
    chk(cap_irq, 1'b0);
    v = 16'($random(seed));
    ld(v);
    pin_to(1'b0, k);
    chk(16'(k), 16'(3 + FILTER_SAMPLES));
    rdcap(capx);
    chk(capx, v);
    wr8(ADDR_CTRL_B, 8'h00);
    wr8(ADDR_CMP_CTRL, 8'h04);
    @(posedge clock_in);
    cmpo <= 1'b1;
    idle(6);
    wr8(ADDR_FLAGS, 8'h20);
    v = 16'($random(seed));
    ld(v);
    @(posedge clock_in);
    cmpo <= 1'b0;
    idle(3);
    chk(cap_irq, 1'b1);
    rdcap(capx);
    chk(capx, v);
    wr8(ADDR_FLAGS, 8'h20);
    wr8(ADDR_CMP_CTRL, 8'h00);
    wr8(ADDR_CTRL_B, 8'h18);
    pin_to(1'b1, k);
    pin_to(1'b0, k);
    chk(cap_irq, 1'b0);
    w = 16'($random(seed));
    wr8(ADDR_CAP_H, w[15:8]);
    wr8(ADDR_CAP_L, w[7:0]);
    rdcap(capx);
    chk(capx, w);
    wr8(ADDR_CTRL_B, 8'h00);
    $display("capture tests done");
    v = 16'(($random(seed) & 16'h7FFF) + 16'h0010);
    for (int c = 0; c < 2; c++)
    begin
      wr8(ADDR_CMP_L_BASE + 4'(2 * c + 1), v[15:8]);
      wr8(ADDR_CMP_L_BASE + 4'(2 * c), v[7:0]);
    end
    chk(cval[0], v);
    rd8(ADDR_CAP_L, lo);
    rd8(ADDR_CMP_L_BASE + 4'h1, hi);
    chk(hi, v[15:8]);
    rd8(4'h3, lo);
    chk(lo, 8'h00);
    for (int c = 0; c < 2; c++)
    begin
      ld(v - 16'(2 * c));
      run <= 1'b1;
      idle(2);
      chk(cmp_irq, 2'b00);
      idle(1);
      chk(cmp_irq, c ? 2'b11 : 2'b00);
      chk(match, c ? 2'b11 : 2'b00);
      run <= 1'b0;
    end
    ack(1'b0, 2'b01);
    wr8(ADDR_FLAGS, 8'h04);
    chk(cmp_irq, 2'b00);
    wr8(ADDR_CTRL_C, 8'hC0);
    chk(frc, 2'b11);
    idle(2);
    chk(cmp_irq, 2'b00);
    wr8(ADDR_CTRL_A, 8'hB1);
    wr8(ADDR_CTRL_B, 8'h08);
    w = 16'($random(seed));
    wr8(ADDR_CMP_L_BASE + 4'h3, w[15:8]);
    wr8(ADDR_CMP_L_BASE + 4'h2, w[7:0]);
    chk(cval[1], v);
    chk(wgm, 4'h5);
    rd8(ADDR_CMP_L_BASE + 4'h2, lo);
    chk(lo, w[7:0]);
    wr8(ADDR_CTRL_C, 8'hC0);
    chk(frc, 2'b00);
    chk(com[0], 2'b10);
    ld(16'h0000);
    @(posedge clock_in);
    run <= 1'b1;
    @(posedge clock_in);
    run <= 1'b0;
    #1;
    chk(cval[1], w);
    $display("compare tests done");
    conclude();
  end
endmodule
